// File: logic/scrs_pkg.sv
// constants for the start-up configuration and reset sequencer
// assumes a single 250 MHz clock and an APB master with 32-bit data
// Notes on behaviour
// - two-speed start on fast RC, then switch
// - initial_osc_select picks the reset clock source
// - switch monitor mode gates switching and monitor
// - osc2 pin: clock out or digital I/O
// - primary_osc_mode selects primary oscillator mode
// - forced watchdog always on, soft bit ignored
// - otherwise soft bit enables watchdog, rc
// - window disable bit picks watchdog window mode
// - PLL switch optionally waits for lock
// - prescale select gives 1:128 or 1:32
// - postscale ratio is two to the code
// - power-up timer delay from por_timer_select
// - scan port enable follows its bit
// - debug channel selects pin pair one to three
// - regulator start-up hold after any power-down
// - brown-out produces a whole-device reset
// - brown-out takes clock source from config
// - oscillator start-up timer gates the clock
// - PLL clock held until lock reads one, except a two-speed switch with the PLL wait bit off
// - power-up delay concurrent, monitor delay fallback
// - brown-out flag in bit one of status
// - brown-out detection active in sleep too
package scrs_pkg;
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   localparam logic [7:0]  OFS_RESET_CTRL = 8'h00;
   localparam logic [7:0]  OFS_CFG_STAT   = 8'h04;
   localparam logic [7:0]  OFS_SEQ_STAT   = 8'h08;
   localparam int          BIT_POR_FLAG   = 0;
   localparam int          BIT_BOR_FLAG   = 1;
   localparam int          BIT_WDT_SOFT   = 5;
   // config word field positions
   localparam int          POS_TWO_SPEED  = 7;
   localparam int          POS_OSC2_FN    = 2;
   localparam int          POS_CSM_HI     = 7;
   localparam int          POS_CSM_LO     = 6;
   localparam int          POS_WDT_FORCE  = 7;
   localparam int          POS_WDT_WINDOW_DISABLE     = 6;
   localparam int          POS_PLL_WAIT   = 5;
   localparam int          POS_WDT_PRE    = 4;
   localparam int          POS_SCAN_EN    = 5;
   // clock source codes
   localparam logic [2:0]  SRC_FRC        = 3'h0;
   localparam logic [2:0]  SRC_FRC_PLL    = 3'h1;
   localparam logic [2:0]  SRC_PRI        = 3'h2;
   localparam logic [2:0]  SRC_PRI_PLL    = 3'h3;
   localparam logic [2:0]  SRC_SEC        = 3'h4;
   localparam logic [2:0]  SRC_LOW_POWER_RC_OSC       = 3'h5;
   localparam logic [2:0]  SRC_FRC_DIV16  = 3'h6;
   localparam logic [2:0]  SRC_FRC_PS     = 3'h7;
   // primary oscillator modes
   localparam logic [1:0]  PRI_EXT_CLK    = 2'h0;
   localparam logic [1:0]  PRI_XTAL_STD   = 2'h1;
   localparam logic [1:0]  PRI_XTAL_HS    = 2'h2;
   localparam logic [1:0]  PRI_OFF        = 2'h3;
   localparam logic [1:0]  DBG_RESERVED   = 2'h0;
   localparam logic [1:0]  DBG_PAIR1_CODE = 2'h3;
   localparam logic [1:0]  DBG_PAIR2_CODE = 2'h2;
   localparam logic [1:0]  WDT_PRE_128    = 2'h1;
   localparam logic [2:0]  POWER_UP_TIMER_OFF       = 3'h0;
   // timing
   localparam int          CLK_MHZ        = 250;
   localparam int          T_STARTUP_US   = 20;
   localparam int          T_FSCM_US      = 100;
   localparam int          T_POWER_UP_TIMER_UNIT_MS = 1;
   localparam int          US_PER_MS      = 1000;
   typedef enum logic [2:0] {ST_REG, ST_CLK, ST_RUN, ST_BOR, ST_SLEEP, ST_WAKE} scrs_state_t;
endpackage : scrs_pkg

// File: logic/scrs_top.sv
// start-up configuration decoder and reset / clock sequencer with APB status
// assumes config words are static and on this clock; detector inputs are async
`timescale 1ns/1ps
module scrs_top
   import scrs_pkg::*;
#(
   parameter int STARTUP_CYC = T_STARTUP_US * CLK_MHZ,
   parameter int FSCM_CYC    = T_FSCM_US * CLK_MHZ,
   parameter int MS_CYC      = T_POWER_UP_TIMER_UNIT_MS * US_PER_MS * CLK_MHZ
)
(
   input  wire logic              MCLK_I,
   input  wire logic              RST_B_I,
   input  wire logic              CE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [DATA_W-1:0] PWDATA_I,
   output logic      [DATA_W-1:0] PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic [7:0]        OSC_SELECT_CFG_I,
   input  wire logic [7:0]        OSC_CFG_I,
   input  wire logic [7:0]        WATCHDOG_CFG_I,
   input  wire logic [7:0]        POR_CFG_I,
   input  wire logic [7:0]        DEBUG_CFG_I,
   input  wire logic              BOR_DET_I,
   input  wire logic              OSC_READY_I,
   input  wire logic              PLL_LOCK_I,
   input  wire logic              SLEEP_I,
   output logic                   CORE_RST_B_O,
   output logic                   EXEC_EN_O,
   output logic                   SYS_CLK_EN_O,
   output logic      [2:0]        CLK_SRC_O,
   output logic      [1:0]        PRI_MODE_O,
   output logic                   PRI_OSC_EN_O,
   output logic                   OSC2_CLKOUT_O,
   output logic                   CLK_SWITCH_EN_O,
   output logic                   FAIL_SAFE_EN_O,
   output logic                   PLL_WAIT_O,
   output logic                   WDT_EN_O,
   output logic                   LOW_POWER_RC_OSC_RUN_O,
   output logic                   WDT_WINDOW_O,
   output logic                   WDT_PRE128_O,
   output logic      [15:0]       WDT_POST_RATIO_O,
   output logic                   SCAN_EN_O,
   output logic      [1:0]        DBG_PAIR_O
);

   scrs_state_t       st_reg;
   scrs_state_t       st_next;
   // two stages suffice at this clock; a third only adds latency
   logic [1:0]        bor_sy_reg;
   logic [1:0]        osc_sy_reg;
   logic [1:0]        pll_sy_reg;
   logic [7:0]        osel_reg;
   logic [7:0]        ocfg_reg;
   logic [7:0]        wcfg_reg;
   logic [7:0]        pcfg_reg;
   logic [7:0]        dcfg_reg;
   logic [31:0]       cnt_reg;
   logic [7:0]        ms_reg;
   logic [2:0]        src_reg;
   logic              pend_reg;
   logic              bor_flag_reg;
   logic              por_flag_reg;
   logic              soft_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              err_reg;

   // second stage only is read
   wire bor_s = bor_sy_reg[1];
   wire osc_s = osc_sy_reg[1];
   wire pll_s = pll_sy_reg[1];

   // decoded configuration
   wire [2:0] tgt_src   = osel_reg[2:0];
   wire       two_req   = osel_reg[POS_TWO_SPEED];
   wire [1:0] pri_mode  = ocfg_reg[1:0];
   wire       wdt_force = wcfg_reg[POS_WDT_FORCE];
   wire       pll_wait  = wcfg_reg[POS_PLL_WAIT];
   wire [2:0] power_up_timer_sel  = pcfg_reg[2:0];
   wire tgt_osc = (tgt_src == SRC_PRI) || (tgt_src == SRC_PRI_PLL) ||
                  (tgt_src == SRC_SEC);
   wire tgt_pll = (tgt_src == SRC_PRI_PLL) || (tgt_src == SRC_FRC_PLL);
   wire xtal    = (pri_mode == PRI_XTAL_STD) || (pri_mode == PRI_XTAL_HS);
   wire two_speed = two_req && (tgt_src != SRC_FRC);
   // oscillator start-up and lock both gate the first clock unless a two-speed start runs it on fast rc
   wire tgt_ready = (!tgt_osc || osc_s) && (!tgt_pll || pll_s);
   wire sw_ok     = (!tgt_osc || osc_s) &&
                    (!tgt_pll || !pll_wait || pll_s);
   wire clk_on    = two_speed || tgt_ready;
   wire use_fscm  = (power_up_timer_sel == POWER_UP_TIMER_OFF) && xtal && tgt_osc;
   wire [7:0] power_up_timer_ms = 8'(1) << power_up_timer_sel;
   wire ms_tick   = (cnt_reg == 32'(MS_CYC - 1));
   wire reg_done  = (cnt_reg == 32'(STARTUP_CYC - 1));
   wire dly_done  = use_fscm ? (cnt_reg >= 32'(FSCM_CYC - 1)) :
                    (power_up_timer_sel == POWER_UP_TIMER_OFF) ? 1'b1 :
                    (ms_reg >= power_up_timer_ms);

   // next state; brown-out wins from any state, sleep included
   always_comb
   begin
      st_next = st_reg;
      if (bor_s)
         st_next = ST_BOR;
      else
         case (st_reg)
            ST_BOR:   st_next = ST_REG;
            ST_REG:   if (reg_done) st_next = ST_CLK;
            ST_CLK:   if (clk_on && dly_done) st_next = ST_RUN;
            ST_RUN:   if (SLEEP_I) st_next = ST_SLEEP;
            ST_SLEEP: if (!SLEEP_I) st_next = ST_WAKE;
            ST_WAKE:  if (reg_done) st_next = ST_RUN;
            default:  st_next = ST_BOR;
         endcase
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         bor_sy_reg <= 2'h0;
         osc_sy_reg <= 2'h0;
         pll_sy_reg <= 2'h0;
      end
      else if (CE_I)
      begin
         bor_sy_reg <= {bor_sy_reg[0], BOR_DET_I};
         osc_sy_reg <= {osc_sy_reg[0], OSC_READY_I};
         pll_sy_reg <= {pll_sy_reg[0], PLL_LOCK_I};
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         st_reg <= ST_REG;
      else if (CE_I)
         st_reg <= st_next;
   end

   // one counter serves regulator, monitor and millisecond ticks
   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         cnt_reg <= 32'h0;
         ms_reg  <= 8'h00;
      end
      else if (CE_I)
      begin
         if (st_next != st_reg)
         begin
            cnt_reg <= 32'h0;
            ms_reg  <= 8'h00;
         end
         else if (st_reg == ST_CLK && !use_fscm && ms_tick)
         begin
            cnt_reg <= 32'h0;
            if (ms_reg != 8'hFF)
               ms_reg <= ms_reg + 8'h01;
         end
         else if (st_reg == ST_REG || st_reg == ST_WAKE || st_reg == ST_CLK)
            cnt_reg <= cnt_reg + 32'h1;
      end
   end

   // fuses are copied only while the regulator hold runs
   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         osel_reg <= 8'h00;
         ocfg_reg <= 8'h00;
         wcfg_reg <= 8'h00;
         pcfg_reg <= 8'h00;
         dcfg_reg <= 8'h00;
      end
      else if (CE_I && st_reg == ST_REG)
      begin
         osel_reg <= OSC_SELECT_CFG_I;
         ocfg_reg <= OSC_CFG_I;
         wcfg_reg <= WATCHDOG_CFG_I;
         pcfg_reg <= POR_CFG_I;
         dcfg_reg <= DEBUG_CFG_I;
      end
   end

   // active clock source and pending two-speed switch
   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         src_reg  <= SRC_FRC;
         pend_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         if (st_reg == ST_CLK)
         begin
            src_reg  <= two_speed ? SRC_FRC : tgt_src;
            pend_reg <= two_speed;
         end
         else if (st_reg == ST_RUN && pend_reg && sw_ok)
         begin
            src_reg  <= tgt_src;
            pend_reg <= 1'b0;
         end
      end
   end

   // apb register access
   wire acc      = PSEL_I && PENABLE_I;
   wire hit_rc   = (PADDR_I == OFS_RESET_CTRL);
   wire hit_cfg  = (PADDR_I == OFS_CFG_STAT);
   wire hit_seq  = (PADDR_I == OFS_SEQ_STAT);
   wire mapped   = hit_rc || hit_cfg || hit_seq;
   wire wr_rc    = acc && PWRITE_I && hit_rc;
   wire [DATA_W-1:0] rc_val  = {26'h0, soft_reg, 3'h0, bor_flag_reg, por_flag_reg};
   wire [DATA_W-1:0] cfg_val = {dcfg_reg, pcfg_reg, wcfg_reg, ocfg_reg};
   wire [DATA_W-1:0] seq_val = {16'h0, osel_reg, pll_s, osc_s, src_reg, st_reg};
   wire [DATA_W-1:0] rd_mux  = hit_rc ? rc_val : hit_cfg ? cfg_val :
                               hit_seq ? seq_val : 32'h0;

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         bor_flag_reg <= 1'b0;
         por_flag_reg <= 1'b1;
         soft_reg     <= 1'b0;
      end
      else if (CE_I)
      begin
         if (bor_s)
            bor_flag_reg <= 1'b1;
         else if (wr_rc)
            bor_flag_reg <= PWDATA_I[BIT_BOR_FLAG];
         if (wr_rc)
            por_flag_reg <= PWDATA_I[BIT_POR_FLAG];
         // soft enable is cleared by every device reset
         if (st_reg == ST_BOR)
            soft_reg <= 1'b0;
         else if (wr_rc)
            soft_reg <= PWDATA_I[BIT_WDT_SOFT];
      end
   end

   always_ff @(posedge MCLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         rdata_reg <= 32'h0;
         err_reg   <= 1'b0;
      end
      else if (CE_I)
      begin
         rdata_reg <= (PSEL_I && !PENABLE_I && !PWRITE_I) ? rd_mux : rdata_reg;
         err_reg   <= PSEL_I && !PENABLE_I && !mapped;
      end
   end

   // zero-wait slave; data captured in the setup cycle
   assign PREADY_O  = 1'b1;
   assign PRDATA_O  = rdata_reg;
   assign PSLVERR_O = acc && err_reg;

   // sequencer outputs
   assign CORE_RST_B_O = (st_reg == ST_RUN) || (st_reg == ST_SLEEP) ||
                         (st_reg == ST_WAKE);
   assign EXEC_EN_O    = (st_reg == ST_RUN);
   assign SYS_CLK_EN_O = (st_reg == ST_RUN) ||
                         ((st_reg == ST_CLK) && clk_on);
   assign CLK_SRC_O    = src_reg;

   // configuration outputs
   assign PRI_MODE_O       = pri_mode;
   assign PRI_OSC_EN_O     = (pri_mode != PRI_OFF);
   assign OSC2_CLKOUT_O    = !xtal && ocfg_reg[POS_OSC2_FN];
   assign CLK_SWITCH_EN_O  = !ocfg_reg[POS_CSM_HI];
   assign FAIL_SAFE_EN_O   = !ocfg_reg[POS_CSM_HI] && !ocfg_reg[POS_CSM_LO];
   assign PLL_WAIT_O       = pll_wait;
   assign WDT_EN_O         = wdt_force || soft_reg;
   // low_power_rc_osc may stop only when the watchdog is off and not the source
   assign LOW_POWER_RC_OSC_RUN_O       = wdt_force || soft_reg || (src_reg == SRC_LOW_POWER_RC_OSC);
   assign WDT_WINDOW_O     = !wcfg_reg[POS_WDT_WINDOW_DISABLE];
   assign WDT_PRE128_O     = (wcfg_reg[POS_WDT_PRE] == WDT_PRE_128[0]);
   assign WDT_POST_RATIO_O = 16'(1) << wcfg_reg[3:0];
   assign SCAN_EN_O        = dcfg_reg[POS_SCAN_EN];
   // reserved code routes nowhere
   assign DBG_PAIR_O = (dcfg_reg[1:0] == DBG_PAIR1_CODE) ? 2'h1 :
                       (dcfg_reg[1:0] == DBG_PAIR2_CODE) ? 2'h2 :
                       (dcfg_reg[1:0] == DBG_RESERVED)   ? 2'h0 : 2'h3;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_B_I);

   chk_bor_holds_reset: assert property (CE_I && bor_s |=> !CORE_RST_B_O)
      else $error("brown-out did not hold reset");
   chk_bor_flag_set: assert property (CE_I && bor_s |=> bor_flag_reg)
      else $error("brown-out flag not set");
   chk_bor_in_sleep: assert property (CE_I && bor_s && st_reg == ST_SLEEP
      |=> st_reg == ST_BOR)
      else $error("brown-out missed in sleep");
   chk_regulator_hold: assert property ($rose(EXEC_EN_O) |->
      $past(cnt_reg) == 32'(STARTUP_CYC - 1) || $past(st_reg) == ST_CLK)
      else $error("execution before regulator hold");
   chk_clock_withheld: assert property (st_reg == ST_CLK && !two_speed &&
      !tgt_ready |-> !SYS_CLK_EN_O)
      else $error("clock released before oscillator ready");
   chk_pll_lock_hold: assert property (st_reg == ST_CLK && !two_speed &&
      tgt_pll && !pll_s |-> !SYS_CLK_EN_O && !CORE_RST_B_O)
      else $error("clock released before lock");
   chk_wdt_force_on: assert property (wdt_force |-> WDT_EN_O && LOW_POWER_RC_OSC_RUN_O)
      else $error("forced watchdog not running");
   chk_wdt_soft_ctl: assert property (!wdt_force && CE_I && wr_rc &&
      st_reg != ST_BOR |=> WDT_EN_O == $past(PWDATA_I[BIT_WDT_SOFT]))
      else $error("soft watchdog enable ignored");
   chk_cfg_held: assert property (st_reg == ST_RUN && $past(st_reg) == ST_RUN
      |-> $stable(wcfg_reg) && $stable(osel_reg) && $stable(ocfg_reg))
      else $error("configuration changed outside reset");
   chk_switch_waits: assert property (st_reg == ST_RUN && pend_reg &&
      tgt_pll && pll_wait && !pll_s |=> src_reg == SRC_FRC)
      else $error("switch did not wait for lock");
   chk_delay_before_run: assert property ($rose(CORE_RST_B_O) |->
      $past(SYS_CLK_EN_O) && ($past(power_up_timer_sel) != POWER_UP_TIMER_OFF ?
      $past(ms_reg) >= $past(power_up_timer_ms) :
      (!$past(use_fscm) || $past(cnt_reg) >= 32'(FSCM_CYC - 1))))
      else $error("reset released before delay");

   // outputs held against what the fuse codes mean
   chk_src_from_cfg: assert property (CE_I && st_reg == ST_CLK && !two_speed
      |=> CLK_SRC_O == tgt_src)
      else $error("clock source not taken from configuration");
   chk_two_speed_frc: assert property (CE_I && st_reg == ST_CLK && two_speed
      |=> CLK_SRC_O == SRC_FRC && pend_reg)
      else $error("two-speed start not on fast rc");
   chk_reg_hold_len: assert property (st_reg == ST_REG
      |-> cnt_reg < 32'(STARTUP_CYC))
      else $error("regulator hold overran");
   chk_bor_flag_kept: assert property (bor_flag_reg && !wr_rc
      |=> bor_flag_reg)
      else $error("brown-out flag lost without a write");
   chk_soft_clr_bor: assert property (CE_I && st_reg == ST_BOR
      |=> !soft_reg)
      else $error("soft enable survived device reset");
   chk_low_power_rc_osc_may_stop: assert property (!wdt_force && !soft_reg && src_reg != SRC_LOW_POWER_RC_OSC
      |-> !LOW_POWER_RC_OSC_RUN_O)
      else $error("low_power_rc_osc kept running when free to stop");
   chk_osc2_xtal_pin: assert property (xtal
      |-> !OSC2_CLKOUT_O)
      else $error("clock driven on osc2 in crystal mode");
   chk_monitor_needs_sw: assert property (FAIL_SAFE_EN_O
      |-> CLK_SWITCH_EN_O)
      else $error("monitor on without clock switching");
   chk_dbg_pair_legal: assert property (dcfg_reg[1:0] != DBG_RESERVED
      |-> DBG_PAIR_O != 2'h0)
      else $error("debug channel not routed");
   chk_post_onehot: assert property ($onehot(WDT_POST_RATIO_O))
      else $error("postscale ratio not a power of two");
   chk_cfg_sampled: assert property (CE_I && st_reg == ST_REG
      |=> wcfg_reg == $past(WATCHDOG_CFG_I) && osel_reg == $past(OSC_SELECT_CFG_I))
      else $error("configuration not sampled in reset");

   cov_bor_event: cover property (bor_s ##1 st_reg == ST_BOR);
   cov_two_speed: cover property (pend_reg ##1 !pend_reg && st_reg == ST_RUN);
   cov_sleep_wake: cover property (st_reg == ST_WAKE ##1 st_reg == ST_RUN);
   cov_fscm_path: cover property (st_reg == ST_CLK && use_fscm ##1 st_reg == ST_RUN);

endmodule : scrs_top

// File: verif/scrs_supply_model.sv
// far-side model: oscillator start-up, pll lock and brown-out detector
// assumes the bench sets the delays; counts restart on any reset
`timescale 1ns/1ps
module scrs_supply_model
(
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        bor_req_i,
   input  wire logic [15:0] ost_dly_i,
   input  wire logic [15:0] lock_dly_i,
   output logic             osc_ready_o,
   output logic             pll_lock_o,
   output logic             bor_det_o
);
   logic [15:0] cnt_reg;
   // oscillator restarts after a dip, so ready and lock drop with it
   always_ff @(posedge mclk_i or negedge rst_b_i)
      if (!rst_b_i)
         cnt_reg <= 16'h0000;
      else if (bor_req_i)
         cnt_reg <= 16'h0000;
      else if (cnt_reg != 16'hFFFF)
         cnt_reg <= cnt_reg + 16'h0001;
   assign osc_ready_o = (cnt_reg >= ost_dly_i);
   assign pll_lock_o  = (cnt_reg >= lock_dly_i);
   assign bor_det_o   = bor_req_i;
endmodule : scrs_supply_model

// File: verif/scrs_top_tb.sv
// self-checking bench for the start-up sequencer and its apb status
// assumes shortened timing parameters and the behavioural supply model
`timescale 1ns/1ps
module scrs_top_tb;
   import scrs_pkg::*;
   localparam int SU = 8;
   localparam int FS = 20;
   localparam int MS = 10;
   logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ce = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, e, g;
   logic        prdy, perr, osc_rdy, lock, bor_det, sleep = 1'b0, bor_req = 1'b0;
   logic [7:0]  c_osel = 8'h00, c_osc = 8'h00, c_wdt = 8'h00, c_por = 8'h00, c_dbg = 8'h00;
   logic [15:0] osc_startup_timer = 16'h0004, lck = 16'h0004, post;
   logic        core_rst_b, exec_en, clk_en, pri_en, osc2, sw_en, fs_en, pll_w, wdt_en;
   logic        low_power_rc_osc, win, pre128, scan_en;
   logic [2:0]  clk_src;
   logic [1:0]  pri_mode, dbg_pair;
   logic [7:0]  sq_src [4] = '{8'h02, 8'h02, 8'h00, 8'h03};
   logic [7:0]  sq_osc [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
   logic [7:0]  sq_por [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
   logic [15:0] sq_lck [4] = '{16'h0004, 16'h0004, 16'h0004, 16'h0032};
   int          sq_lo [4] = '{SU + 8 * MS, SU + FS, SU, 50};
   int          n_mismatch = 0;
   int          checks = 0;
   int          cyc = 0;
   always #2 mclk = ~mclk;
   always @(posedge mclk) cyc <= rst_b ? cyc + 1 : 0;
   scrs_top #(.STARTUP_CYC(SU), .FSCM_CYC(FS), .MS_CYC(MS)) u_dut
   (
      .MCLK_I(mclk), .RST_B_I(rst_b), .CE_I(ce), .PADDR_I(paddr), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .OSC_SELECT_CFG_I(c_osel), .OSC_CFG_I(c_osc),
      .WATCHDOG_CFG_I(c_wdt), .POR_CFG_I(c_por), .DEBUG_CFG_I(c_dbg), .BOR_DET_I(bor_det),
      .OSC_READY_I(osc_rdy), .PLL_LOCK_I(lock), .SLEEP_I(sleep), .CORE_RST_B_O(core_rst_b),
      .EXEC_EN_O(exec_en), .SYS_CLK_EN_O(clk_en), .CLK_SRC_O(clk_src),
      .PRI_MODE_O(pri_mode), .PRI_OSC_EN_O(pri_en), .OSC2_CLKOUT_O(osc2),
      .CLK_SWITCH_EN_O(sw_en), .FAIL_SAFE_EN_O(fs_en), .PLL_WAIT_O(pll_w),
      .WDT_EN_O(wdt_en), .LOW_POWER_RC_OSC_RUN_O(low_power_rc_osc), .WDT_WINDOW_O(win), .WDT_PRE128_O(pre128),
      .WDT_POST_RATIO_O(post), .SCAN_EN_O(scan_en), .DBG_PAIR_O(dbg_pair)
   );
   scrs_supply_model u_supply
   (
      .mclk_i(mclk), .rst_b_i(rst_b), .bor_req_i(bor_req), .ost_dly_i(osc_startup_timer),
      .lock_dly_i(lck), .osc_ready_o(osc_rdy), .pll_lock_o(lock), .bor_det_o(bor_det)
   );
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
      end
   endtask : cmp
   task automatic cmp_rng(input string nm, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, got);
      end
   endtask : cmp_rng
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      input logic [31:0] exp, input logic exp_err);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pen <= 1'b0;
      paddr <= a;
      pwr <= w;
      pwd <= wd;
      @(posedge mclk);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (prdy !== 1'b1 && n < 20);
      if (n >= 20)
         n_mismatch++;
      if (!w)
         cmp("rdata", exp, prd);
      cmp("slverr", {31'h0, exp_err}, {31'h0, perr});
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rst_run();
      rst_b <= 1'b0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
   endtask : rst_run
   task automatic wait_exec(output int n);
      @(posedge mclk);
      while (exec_en !== 1'b1 && cyc < 5000)
         @(posedge mclk);
      n = cyc;
   endtask : wait_exec
   task automatic wait_cyc(input int t);
      while (cyc < t)
         @(posedge mclk);
   endtask : wait_cyc
   initial
   begin
      int t;
      int n;
      logic [3:0] c;
      rst_run();
      apb(8'h00, 1'b0, 32'h0, 32'h0000_0001, 1'b0);
      apb(8'h0C, 1'b0, 32'h0, 32'h0, 1'b1);
      $display("test reset values done");
      for (int i = 0; i < 16; i++)
      begin
         c = i[3:0];
         c_osel <= {5'h00, c[2:0]};
         c_osc <= {c[1:0], 3'h0, c[2], c[1:0]};
         c_wdt <= {c[0], c[1], c[2], c[3], c};
         c_dbg <= {2'h0, c[0], 3'h0, c[1:0]};
         rst_run();
         repeat (3) @(posedge mclk);
         e = {~c[1], c[1:0] == 2'h0, c[1:0], c[1:0] != 2'h3, c[2] & (c[1] ~^ c[0]),
              c[0], ~c[1], c[3], c[0], c[2], 2'h0 - c[1:0]};
         g = {sw_en, fs_en, pri_mode, pri_en, osc2, wdt_en, win, pre128, scan_en, pll_w,
              dbg_pair};
         cmp("decode", e, g);
         cmp("post ratio", 32'h1 << c, {16'h0, post});
         if (c[0])
            cmp("low_power_rc_osc forced", 32'h1, {31'h0, low_power_rc_osc});
      end
      $display("test decode done");
      c_wdt <= 8'h40;
      c_dbg <= 8'h00;
      for (int k = 0; k < 4; k++)
      begin
         c_osel <= sq_src[k];
         c_osc <= sq_osc[k];
         c_por <= sq_por[k];
         lck <= sq_lck[k];
         rst_run();
         wait_exec(t);
         cmp_rng("exec delay", sq_lo[k], sq_lo[k] + 14, t);
         cmp("clk src", {29'h0, sq_src[k][2:0]}, {29'h0, clk_src});
         cmp("clk en", 32'h1, {31'h0, clk_en});
      end
      $display("test sequence done");
      c_osc <= 8'h00;
      c_por <= 8'h00;
      osc_startup_timer <= 16'h001E;
      lck <= 16'h003C;
      for (int k = 0; k < 2; k++)
      begin
         c_osel <= 8'h83;
         c_wdt <= k ? 8'h40 : 8'h60;
         rst_run();
         wait_exec(t);
         cmp("fast start", {29'h0, SRC_FRC}, {29'h0, clk_src});
         wait_cyc(48);
         e = k ? {29'h0, SRC_PRI_PLL} : {29'h0, SRC_FRC};
         cmp("lock wait", e, {29'h0, clk_src});
         wait_cyc(80);
         cmp("switched", {29'h0, SRC_PRI_PLL}, {29'h0, clk_src});
      end
      $display("test two speed done");
      osc_startup_timer <= 16'h0004;
      c_osel <= 8'h00;
      c_wdt <= 8'h40;
      rst_run();
      wait_exec(t);
      cmp("wdt off", 32'h0, {31'h0, wdt_en});
      apb(8'h00, 1'b1, 32'h0000_0020, 32'h0, 1'b0);
      @(posedge mclk);
      cmp("wdt soft", 32'h3, {30'h0, wdt_en, low_power_rc_osc});
      apb(8'h00, 1'b0, 32'h0, 32'h0000_0020, 1'b0);
      apb(8'h04, 1'b0, 32'h0, 32'h0000_4000, 1'b0);
      c_osel <= 8'h05;
      repeat (4) @(posedge mclk);
      cmp("held src", 32'h0, {29'h0, clk_src});
      sleep <= 1'b1;
      repeat (4) @(posedge mclk);
      cmp("sleep exec", 32'h0, {31'h0, exec_en});
      sleep <= 1'b0;
      t = cyc;
      // clock enable low for five edges stretches the wake hold by five
      @(posedge mclk);
      ce <= 1'b0;
      repeat (5) @(posedge mclk);
      ce <= 1'b1;
      wait_exec(n);
      cmp_rng("wake hold", SU + 5, SU + 11, n - t);
      $display("test watchdog soft done");
      sleep <= 1'b1;
      repeat (3) @(posedge mclk);
      bor_req <= 1'b1;
      repeat (4) @(posedge mclk);
      cmp("bor reset", 32'h0, {30'h0, core_rst_b, exec_en});
      sleep <= 1'b0;
      bor_req <= 1'b0;
      t = cyc;
      wait_exec(n);
      cmp_rng("bor restart", SU, SU + 14, n - t);
      cmp("bor src", {29'h0, SRC_LOW_POWER_RC_OSC}, {29'h0, clk_src});
      apb(8'h00, 1'b0, 32'h0, 32'h0000_0002, 1'b0);
      $display("test brown-out done");
      close_out();
   end
   // tests need about 600 cycles; this leaves a wide margin
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end
endmodule : scrs_top_tb
